/* File: include/buck_seq_defs.svh */
// timing and sizing constants for the buck sequencing and over-voltage logic
// assumes a single 10 MHz core clock; figures are in their own units, cycles derived
`ifndef BUCK_SEQ_DEFS_SVH
`define BUCK_SEQ_DEFS_SVH

// =====================================================
// clock
`define CLK_PERIOD_NS 100

// =====================================================
// times as figures, in their own units
`define OV_DEBOUNCE_NS 1000
`define NEG_OFF_MIN_NS 50
`define MIN_ON_NS 50
`define MIN_OFF_NS 160
`define RESET_INTERVAL_NS 100000
`define SOFT_START_NS 1000000
`define PG_DELAY_NS 500000
`define HICCUP_NS 10000000

// =====================================================
// least times round up, never below one cycle
`define CYC_UP(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define OV_DEBOUNCE_CYC `CYC_UP(`OV_DEBOUNCE_NS)
`define NEG_OFF_CYC `CYC_UP(`NEG_OFF_MIN_NS)
`define MIN_ON_CYC `CYC_UP(`MIN_ON_NS)
`define MIN_OFF_CYC `CYC_UP(`MIN_OFF_NS)
`define RESET_CYC `CYC_UP(`RESET_INTERVAL_NS)
`define SOFT_START_CYC `CYC_UP(`SOFT_START_NS)
`define PG_DELAY_CYC `CYC_UP(`PG_DELAY_NS)
`define HICCUP_CYC `CYC_UP(`HICCUP_NS)

// =====================================================
// widths
`define SEQ_CNT_W 24
`define DELAY_W 16
`define DEB_CNT_W 4
`define PULSE_CNT_W 3

`endif

/* File: include/buck_seq_pkg.sv */
// types shared by the buck sequencing and over-voltage logic
// assumes nothing beyond a SystemVerilog compiler
package buck_seq_pkg;

  // =====================================================
  // per-channel sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RESET,
    ST_DELAY,
    ST_SOFT,
    ST_PGDLY,
    ST_RUN,
    ST_HICCUP
  } seq_state_t;

  // =====================================================
  // per-channel feedback and current comparator bundle
  typedef struct packed {
    logic overvoltage_level_one;
    logic overvoltage_level_two;
    logic below_clear_level;
    logic negative_current;
  } feedback_sense_t;

endpackage : buck_seq_pkg

/* File: hw/buck_sequencing_ovp_logic.sv */
// start-up sequencing, memory-rail mode and two-level over-voltage control for two channels
// assumes comparator outputs arrive asynchronously; delays, pwm and hiccup requests are core-clock logic
//
// What this block does
// - ramp after enable, ready, reset, delay
// - no discharge; low side off before ramp
// - enable follows hysteretic enable comparator
// - grounded delay-two pin latches memory mode
// - memory mode: first delay for both
// - memory mode: both channels hiccup together
// - level one: power-good low, high off, low on
// - level one: negative current drops low side
// - level two: high off, low on
// - level two ignores negative current
// - clear both levels below clear threshold
// - level two armed soft-start, disarmed hiccup
// - level one armed after power-good delay
`timescale 1ns/1ns
`include "buck_seq_defs.svh"

module buck_sequencing_ovp_logic
  import buck_seq_pkg::*;
#(
  parameter int RESET_CYC = `RESET_CYC,
  parameter int SOFT_START_CYC = `SOFT_START_CYC,
  parameter int PG_DELAY_CYC = `PG_DELAY_CYC,
  parameter int HICCUP_CYC = `HICCUP_CYC,
  parameter int DEB_CYC = `OV_DEBOUNCE_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  input wire logic CHANNEL1_ENABLE_IN,
  input wire logic CHANNEL2_ENABLE_IN,
  input wire logic INTERNAL_SUPPLY_READY_IN,
  input wire logic DRIVER_READY_IN,
  input wire logic MEMMODE_PIN_GROUNDED_IN,
  input wire feedback_sense_t CH1_FEEDBACK_SENSE_IN,
  input wire feedback_sense_t CH2_FEEDBACK_SENSE_IN,
  input wire logic [`DELAY_W-1:0] FIRST_DELAY_CYCLES_IN,
  input wire logic [`DELAY_W-1:0] SECOND_DELAY_CYCLES_IN,
  input wire logic [1:0] HICCUP_REQUEST_IN,
  input wire logic [1:0] PWM_REQUEST_IN,
  output logic [1:0] HIGH_SIDE_OUT,
  output logic [1:0] LOW_SIDE_OUT,
  output logic [1:0] POWER_GOOD_OUT,
  output logic [1:0] OV_LEVEL_ONE_OUT,
  output logic [1:0] OV_LEVEL_TWO_OUT,
  output logic MEMORY_MODE_OUT
);

  localparam int DEB_LAST = DEB_CYC - 1;

  // =====================================================
  // synchronisers
  logic [4:0] ctl_meta;
  logic [4:0] ctl_sync;
  feedback_sense_t fb_meta [2];
  feedback_sense_t fb_sync [2];

  // two flops on every comparator input
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ctl_meta <= 5'h00;
      ctl_sync <= 5'h00;
      fb_meta[0] <= '0;
      fb_meta[1] <= '0;
      fb_sync[0] <= '0;
      fb_sync[1] <= '0;
    end else begin
      ctl_meta <= {MEMMODE_PIN_GROUNDED_IN, DRIVER_READY_IN, INTERNAL_SUPPLY_READY_IN,
                   CHANNEL2_ENABLE_IN, CHANNEL1_ENABLE_IN};
      ctl_sync <= ctl_meta;
      fb_meta[0] <= CH1_FEEDBACK_SENSE_IN;
      fb_meta[1] <= CH2_FEEDBACK_SENSE_IN;
      fb_sync[0] <= fb_meta[0];
      fb_sync[1] <= fb_meta[1];
    end
  end

  logic [1:0] en_s;
  logic ready_s;
  logic mem_pin_s;
  assign en_s = ctl_sync[1:0];
  assign ready_s = ctl_sync[2] & ctl_sync[3];
  assign mem_pin_s = ctl_sync[4];

  // =====================================================
  // sequencer
  function automatic logic is_ramping(input seq_state_t s);
    is_ramping = (s == ST_SOFT) || (s == ST_PGDLY) || (s == ST_RUN);
  endfunction : is_ramping

  seq_state_t state [2];
  seq_state_t next_state [2];
  logic [`SEQ_CNT_W-1:0] cnt [2];
  logic [`SEQ_CNT_W-1:0] next_cnt [2];
  logic mem_mode;
  logic next_mem_mode;
  logic [`DELAY_W-1:0] delay_sel [2];
  logic [1:0] hic_take;

  // channel state machines, memory-mode latch and delay choice
  always_comb begin
    next_mem_mode = mem_mode;
    if (state[0] == ST_IDLE && state[1] == ST_IDLE) begin
      next_mem_mode = mem_pin_s;
    end
    delay_sel[0] = FIRST_DELAY_CYCLES_IN;
    delay_sel[1] = mem_mode ? FIRST_DELAY_CYCLES_IN : SECOND_DELAY_CYCLES_IN;
    hic_take = mem_mode ? {2{|HICCUP_REQUEST_IN}} : HICCUP_REQUEST_IN;
    for (int i = 0; i < 2; i++) begin
      next_state[i] = state[i];
      next_cnt[i] = cnt[i] + `SEQ_CNT_W'(1);
      case (state[i])
        ST_IDLE: begin
          next_cnt[i] = '0;
          if (en_s[i] && ready_s) begin
            next_state[i] = ST_RESET;
          end
        end
        ST_RESET: begin
          if (cnt[i] >= `SEQ_CNT_W'(RESET_CYC - 1)) begin
            next_state[i] = ST_DELAY;
            next_cnt[i] = '0;
          end
        end
        ST_DELAY: begin
          if (cnt[i] >= `SEQ_CNT_W'(delay_sel[i])) begin
            next_state[i] = ST_SOFT;
            next_cnt[i] = '0;
          end
        end
        ST_SOFT: begin
          if (cnt[i] >= `SEQ_CNT_W'(SOFT_START_CYC - 1)) begin
            next_state[i] = ST_PGDLY;
            next_cnt[i] = '0;
          end
        end
        ST_PGDLY: begin
          if (cnt[i] >= `SEQ_CNT_W'(PG_DELAY_CYC - 1)) begin
            next_state[i] = ST_RUN;
            next_cnt[i] = '0;
          end
        end
        ST_RUN: begin
          next_cnt[i] = '0;
        end
        ST_HICCUP: begin
          if (cnt[i] >= `SEQ_CNT_W'(HICCUP_CYC - 1)) begin
            next_state[i] = ST_IDLE;
            next_cnt[i] = '0;
          end
        end
        default: begin
          next_state[i] = ST_IDLE;
          next_cnt[i] = '0;
        end
      endcase
      if (hic_take[i] && is_ramping(state[i])) begin
        next_state[i] = ST_HICCUP;
        next_cnt[i] = '0;
      end
      if (!(en_s[i] && ready_s) && state[i] != ST_HICCUP) begin
        next_state[i] = ST_IDLE;
        next_cnt[i] = '0;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state[0] <= ST_IDLE;
      state[1] <= ST_IDLE;
      cnt[0] <= '0;
      cnt[1] <= '0;
      mem_mode <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      mem_mode <= next_mem_mode;
    end
  end

  // =====================================================
  // over-voltage detection
  logic [`DEB_CNT_W-1:0] deb1 [2];
  logic [`DEB_CNT_W-1:0] deb2 [2];
  logic [`DEB_CNT_W-1:0] next_deb1 [2];
  logic [`DEB_CNT_W-1:0] next_deb2 [2];
  logic [1:0] ov1;
  logic [1:0] ov2;
  logic [1:0] next_ov1;
  logic [1:0] next_ov2;
  logic [1:0] arm1;
  logic [1:0] arm2;

  // debounce, arm window and clear per channel; a set outranks a clear
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      arm2[i] = is_ramping(state[i]);
      arm1[i] = (state[i] == ST_RUN);
      next_deb1[i] = '0;
      next_deb2[i] = '0;
      if (arm1[i] && fb_sync[i].overvoltage_level_one && deb1[i] != `DEB_CNT_W'(DEB_CYC - 1)) begin
        next_deb1[i] = deb1[i] + `DEB_CNT_W'(1);
      end
      if (arm2[i] && fb_sync[i].overvoltage_level_two && deb2[i] != `DEB_CNT_W'(DEB_CYC - 1)) begin
        next_deb2[i] = deb2[i] + `DEB_CNT_W'(1);
      end
      next_ov1[i] = ov1[i];
      next_ov2[i] = ov2[i];
      if (fb_sync[i].below_clear_level) begin
        next_ov1[i] = 1'b0;
        next_ov2[i] = 1'b0;
      end
      if (arm1[i] && fb_sync[i].overvoltage_level_one && deb1[i] == `DEB_CNT_W'(DEB_CYC - 1)) begin
        next_ov1[i] = 1'b1;
      end
      if (arm2[i] && fb_sync[i].overvoltage_level_two && deb2[i] == `DEB_CNT_W'(DEB_CYC - 1)) begin
        next_ov2[i] = 1'b1;
      end
      if (!arm1[i]) begin
        next_ov1[i] = 1'b0;
      end
      if (!arm2[i]) begin
        next_ov2[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      deb1[0] <= '0;
      deb1[1] <= '0;
      deb2[0] <= '0;
      deb2[1] <= '0;
      ov1 <= 2'h0;
      ov2 <= 2'h0;
    end else begin
      deb1 <= next_deb1;
      deb2 <= next_deb2;
      ov1 <= next_ov1;
      ov2 <= next_ov2;
    end
  end

  // =====================================================
  // switch commands and power-good
  logic [`PULSE_CNT_W-1:0] held [2];
  logic [`PULSE_CNT_W-1:0] next_held [2];
  logic [`PULSE_CNT_W-1:0] neg_off [2];
  logic [`PULSE_CNT_W-1:0] next_neg_off [2];
  logic [1:0] want_hs;
  logic [1:0] next_hs;
  logic [1:0] next_ls;
  logic [1:0] next_pg;

  // stretch high-side pulses, force protection states, gate low side
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      want_hs[i] = is_ramping(state[i]) && !ov1[i] && !ov2[i] && PWM_REQUEST_IN[i];
      next_hs[i] = HIGH_SIDE_OUT[i];
      next_held[i] = (held[i] == '1) ? held[i] : held[i] + `PULSE_CNT_W'(1);
      if (want_hs[i] != HIGH_SIDE_OUT[i] &&
          held[i] >= (HIGH_SIDE_OUT[i] ? `PULSE_CNT_W'(`MIN_ON_CYC) : `PULSE_CNT_W'(`MIN_OFF_CYC))) begin
        next_hs[i] = want_hs[i];
        next_held[i] = `PULSE_CNT_W'(1);
      end
      next_neg_off[i] = (neg_off[i] == '0) ? neg_off[i] : neg_off[i] - `PULSE_CNT_W'(1);
      if (ov1[i] && !ov2[i] && fb_sync[i].negative_current) begin
        next_neg_off[i] = `PULSE_CNT_W'(`NEG_OFF_CYC);
      end
      if (ov2[i]) begin
        next_ls[i] = 1'b1;
      end else if (ov1[i]) begin
        next_ls[i] = !fb_sync[i].negative_current && neg_off[i] == '0;
      end else if (is_ramping(state[i])) begin
        next_ls[i] = !next_hs[i];
      end else begin
        next_ls[i] = 1'b0;
      end
      next_pg[i] = (state[i] == ST_RUN) && !ov1[i] && !ov2[i];
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      held[0] <= '1;
      held[1] <= '1;
      neg_off[0] <= '0;
      neg_off[1] <= '0;
      HIGH_SIDE_OUT <= 2'h0;
      LOW_SIDE_OUT <= 2'h0;
      POWER_GOOD_OUT <= 2'h0;
    end else begin
      held <= next_held;
      neg_off <= next_neg_off;
      HIGH_SIDE_OUT <= next_hs;
      LOW_SIDE_OUT <= next_ls;
      POWER_GOOD_OUT <= next_pg;
    end
  end

  assign OV_LEVEL_ONE_OUT = ov1;
  assign OV_LEVEL_TWO_OUT = ov2;
  assign MEMORY_MODE_OUT = mem_mode;

  // =====================================================
  // checks on channel one, and on channel two for the shared delay and joint hiccup
  sequence ramp_start_s;
    state[0] == ST_SOFT && $past(state[0]) != ST_SOFT;
  endsequence

  ramp_after_delay_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    ramp_start_s |-> $past(state[0]) == ST_DELAY && $past(en_s[0]) && $past(ready_s))
    else $error("ramp began without enable, ready and delay");
  prebias_low_off_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    !is_ramping(state[0]) && !ov1[0] && !ov2[0] |=> !LOW_SIDE_OUT[0])
    else $error("low side on before ramp");
  enable_drop_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    !en_s[0] && state[0] != ST_HICCUP |=> state[0] == ST_IDLE)
    else $error("channel kept running without enable");
  memmode_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    state[0] != ST_IDLE |=> $stable(mem_mode))
    else $error("memory mode changed after start-up");
  shared_delay_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    mem_mode && state[1] == ST_DELAY && cnt[1] == `SEQ_CNT_W'(FIRST_DELAY_CYCLES_IN) |=> state[1] != ST_DELAY)
    else $error("channel two delay not shared");
  joint_hiccup_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    mem_mode && HICCUP_REQUEST_IN[0] && is_ramping(state[1]) && en_s[1] && ready_s |=> state[1] == ST_HICCUP)
    else $error("channel two missed joint hiccup");
  ov_one_force_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    $rose(ov1[0]) |=> !POWER_GOOD_OUT[0] ##[0:2] !HIGH_SIDE_OUT[0])
    else $error("level one did not force outputs");
  neg_current_off_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    ov1[0] && !ov2[0] && fb_sync[0].negative_current |=> !LOW_SIDE_OUT[0])
    else $error("low side stayed on through negative current");
  ov_two_low_on_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    ov2[0] |=> LOW_SIDE_OUT[0] && !POWER_GOOD_OUT[0])
    else $error("low side dropped under level two");
  debounce_span_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    $rose(ov2[0]) |-> $past(deb2[0]) == `DEB_CNT_W'(DEB_LAST))
    else $error("level two set before full debounce");
  clear_level_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    ov1[0] && fb_sync[0].below_clear_level && !fb_sync[0].overvoltage_level_one |=> !ov1[0])
    else $error("level one not cleared");
  arm_window_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    ov1[0] |-> $past(state[0]) == ST_RUN)
    else $error("level one active outside its window");
  min_off_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    $fell(HIGH_SIDE_OUT[0]) |=> !HIGH_SIDE_OUT[0])
    else $error("high side off time below minimum");

endmodule : buck_sequencing_ovp_logic

/* File: tb/far_side_model.sv */
// far-side comparator model: turns a bench-chosen feedback level into comparator outputs
// assumes the bench changes level and current requests away from the clock edge
`timescale 1ns/1ns

module far_side_model
  import buck_seq_pkg::*;
(
  input wire logic [3:0] level_in,
  input wire logic [1:0] neg_req_in,
  output feedback_sense_t ch1_sense_out,
  output feedback_sense_t ch2_sense_out
);
  // ==========================================================
  // level code: 0 regulating, 1 above first, 2 above second, 3 between clear and first
  function automatic feedback_sense_t sense(input logic [1:0] code, input logic neg);
    feedback_sense_t s;
    s.overvoltage_level_one = (code == 2'h1) || (code == 2'h2);
    s.overvoltage_level_two = (code == 2'h2);
    s.below_clear_level = (code == 2'h0);
    s.negative_current = neg;
    return s;
  endfunction : sense

  // ==========================================================
  // comparator outputs per channel
  assign ch1_sense_out = sense(level_in[1:0], neg_req_in[0]);
  assign ch2_sense_out = sense(level_in[3:2], neg_req_in[1]);
endmodule : far_side_model

/* File: tb/testbench.sv */
// self-checking bench for the buck sequencing and over-voltage logic
// assumes short sim parameters; events are noted in a queue and matched by a watcher
`timescale 1ns/1ns
`include "buck_seq_defs.svh"

module testbench
  import buck_seq_pkg::*;
;
  localparam int RST = 4;
  localparam int SS = 8;
  localparam int PGD = 8;
  localparam int HIC = 16;
  localparam int DEB = 10;
  localparam int START = 3 + RST + 1 + SS + PGD + 1; // sync, reset, soft, pg delay; plus delay
  typedef struct {logic [3:0] kind; int cycle;} note_t;
  logic clock, nrst, en1, en2, supply, drv, memmode, mem;
  logic [1:0] hic, hs, ls, pg, ov1, ov2, neg_req, pg_d, ov1_d, ov2_d;
  logic [1:0] pwm = 2'h0;
  logic [15:0] first_delay_pin, dly2;
  logic [15:0] lfsr = 16'h788A;
  logic [3:0] level;
  feedback_sense_t s1, s2;
  int cyc = 0;
  int fail_count, n_compared;
  note_t notes[$];

  buck_sequencing_ovp_logic #(.RESET_CYC(RST), .SOFT_START_CYC(SS), .PG_DELAY_CYC(PGD), .HICCUP_CYC(HIC),
    .DEB_CYC(DEB)) i_buck_sequencing_ovp_logic (.CLOCK_IN(clock), .NRST_IN(nrst), .CHANNEL1_ENABLE_IN(en1),
    .CHANNEL2_ENABLE_IN(en2), .INTERNAL_SUPPLY_READY_IN(supply), .DRIVER_READY_IN(drv),
    .MEMMODE_PIN_GROUNDED_IN(memmode), .CH1_FEEDBACK_SENSE_IN(s1), .CH2_FEEDBACK_SENSE_IN(s2),
    .FIRST_DELAY_CYCLES_IN(first_delay_pin), .SECOND_DELAY_CYCLES_IN(dly2), .HICCUP_REQUEST_IN(hic),
    .PWM_REQUEST_IN(pwm), .HIGH_SIDE_OUT(hs), .LOW_SIDE_OUT(ls), .POWER_GOOD_OUT(pg),
    .OV_LEVEL_ONE_OUT(ov1), .OV_LEVEL_TWO_OUT(ov2), .MEMORY_MODE_OUT(mem));

  far_side_model i_far_side_model (.level_in(level), .neg_req_in(neg_req), .ch1_sense_out(s1),
    .ch2_sense_out(s2));

  // ==========================================================
  // clock, cycle count and hang guard
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 1500) begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end

  // random modulator requests
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  always @(negedge clock) begin
    lfsr <= lfsr_next(lfsr);
    pwm <= lfsr[1:0];
  end

  // ==========================================================
  // checking tasks
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task automatic expect_event(input logic [3:0] kind, input int after);
    notes.push_back('{kind, cyc + after});
  endtask : expect_event
  task automatic compare_bits(input logic [2:0] got, input logic [2:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask : compare_bits
  task automatic compare_event(input logic [3:0] kind);
    note_t n;
    n_compared++;
    if (notes.size() == 0) begin
      fail_count++;
      $display("unexpected at %0t: event %h with no note", $time, kind);
    end else begin
      n = notes.pop_front();
      if (n.kind !== kind || cyc < n.cycle - 2 || cyc > n.cycle + 2) begin
        fail_count++;
        $display("unexpected at %0t: event %h at cycle %0d", $time, kind, cyc);
      end
    end
  endtask : compare_event
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // ==========================================================
  // watcher: each rising flag takes the oldest note
  always @(negedge clock) begin
    for (int c = 0; c < 2; c++) begin
      if (pg[c] === 1'b1 && pg_d[c] !== 1'b1) compare_event(4'(c));
      if (ov1[c] === 1'b1 && ov1_d[c] !== 1'b1) compare_event(4'(4 + c));
      if (ov2[c] === 1'b1 && ov2_d[c] !== 1'b1) compare_event(4'(8 + c));
    end
    pg_d = pg;
    ov1_d = ov1;
    ov2_d = ov2;
  end

  // ==========================================================
  // main sequence
  initial begin
    clock = 0; nrst = 0; en1 = 0; en2 = 0; supply = 1; drv = 1; memmode = 0; hic = 2'h0;
    first_delay_pin = 16'h0003; dly2 = 16'h000C; level = 4'h0; neg_req = 2'h0;
    fail_count = 0; n_compared = 0; pg_d = 2'h0; ov1_d = 2'h0; ov2_d = 2'h0;
    tick(3);
    nrst = 1;
    tick(4);
    // independent start-up, each with its own delay
    en1 = 1;
    en2 = 1;
    expect_event(4'h0, START + 3);
    expect_event(4'h1, START + 12);
    tick(7);
    compare_bits({hs[0], ls}, 3'h0, "pre-ramp switches");
    compare_bits({2'h0, mem}, 3'h0, "memory mode off");
    tick(1);
    level[3:2] = 2'h1; // above first level before the run state
    tick(22);
    level[3:2] = 2'h0;
    tick(20);
    en1 = 0;
    tick(5);
    compare_bits({1'b0, pg}, 3'h2, "power good after enable drop");
    drv = 0;
    tick(5);
    compare_bits({1'b0, pg}, 3'h0, "power good after driver drop");
    drv = 1;
    en1 = 1;
    expect_event(4'h0, START + 3);
    expect_event(4'h1, START + 12);
    tick(45);
    // first level with an interrupted debounce
    level[1:0] = 2'h1;
    tick(8);
    level[1:0] = 2'h3;
    tick(2);
    level[1:0] = 2'h1;
    expect_event(4'h4, DEB + 2);
    tick(14);
    compare_bits({pg[0], hs[0], ls[0]}, 3'h1, "first level switches");
    neg_req[0] = 1;
    tick(4);
    compare_bits({1'b0, ls[0], hs[0]}, 3'h0, "negative current");
    neg_req[0] = 0;
    tick(4);
    compare_bits({2'h0, ls[0]}, 3'h1, "low side back on");
    // second level keeps low side on under negative current
    neg_req[0] = 1;
    level[1:0] = 2'h2;
    expect_event(4'h8, DEB + 2);
    tick(14);
    compare_bits({pg[0], hs[0], ls[0]}, 3'h1, "second level switches");
    neg_req[0] = 0;
    level[1:0] = 2'h0;
    expect_event(4'h0, 4); // power good back, no hiccup
    tick(5);
    compare_bits({1'b0, ov1[0], ov2[0]}, 3'h0, "flags cleared");
    compare_bits({2'h0, pg[1]}, 3'h1, "other channel kept");
    tick(20);
    // memory-rail mode: shared delay and joint hiccup
    en1 = 0;
    en2 = 0;
    tick(6);
    memmode = 1;
    tick(6);
    en1 = 1;
    en2 = 1;
    expect_event(4'h0, START + 3);
    expect_event(4'h1, START + 3);
    tick(45);
    compare_bits({2'h0, mem}, 3'h1, "memory mode latched");
    hic = 2'h1;
    expect_event(4'h0, HIC + START + 2); // both restart after the joint hiccup
    expect_event(4'h1, HIC + START + 2);
    tick(2);
    hic = 2'h0;
    tick(4);
    compare_bits({1'b0, pg}, 3'h0, "joint hiccup");
    tick(60);
    compare_bits({2'h0, notes.size() == 0}, 3'h1, "events outstanding");
    results();
  end
endmodule : testbench
